/* src/mbag_pkg.sv */
// Shared constants, register map and carrier types for the modulo and
// bit-reversed address generator. Assumes one core clock and an APB master.
//
// What this block does
// [RL1] One circular buffer in X space, one independent in Y; any pointer register.
// [RL2] Software avoids frame pointer and stack pointer as circular pointers.
// [RL3] Power-of-two buffers work both ways; boundary check by modifier sign.
// [RL4] Each buffer has 16-bit start and end boundary registers, X pair and Y pair.
// [RL5] Y circular addresses always have their least significant bit cleared.
// [RL6] Length comes from end minus start plus one; up to 64 Kbytes handled.
// [RL7] Pointer-select 1111 disables circular correction for that space.
// [RL8] X correction needs X select not 1111 and X enable bit 15.
// [RL9] Y correction needs Y select not 1111 and Y enable bit 14.
// [RL10] Past-the-limit addresses are detected and wrapped, not only exact hits.
// [RL11] Pointer written back only for pre- or post-modify; indexed leaves it.
// [RL12] Bit reversal lives only in the X write generator, writes only.
// [RL13] Only the modifier is bit-reversed; pointer stays in normal order.
// [RL14] Bit reversal needs select not 1111, enable bit 15, pre/post increment.
// [RL15] Software aligns a 2^N byte reversed buffer to N zero low bits.
// [RL16] The 15-bit pivot is scaled by two to byte addressing.
// [RL17] Byte writes or other modes give normal addresses despite reversal enabled.
// [RL18] Reversed result is pointer plus reversed-carry pivot; offset ignored; LSb clear.
// [RL19] Bit reversal beats circular correction on the same pointer for writes.
// [RL20] Software waits one instruction after modifier write before reversed reads.
// [RL21] Reversed-carry addition carries from the top bit toward the bottom.

`default_nettype none

package mbag_pkg;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam logic [7:0] MBAG_OFF_X_START   = 8'h00;
  localparam logic [7:0] MBAG_OFF_X_END     = 8'h04;
  localparam logic [7:0] MBAG_OFF_Y_START   = 8'h08;
  localparam logic [7:0] MBAG_OFF_Y_END     = 8'h0c;
  localparam logic [7:0] MBAG_OFF_MODE_CTL  = 8'h10;
  localparam logic [7:0] MBAG_OFF_BREV_MOD  = 8'h14;
  localparam logic [7:0] MBAG_OFF_BREV_LAST = 8'h18;

  localparam logic [15:0] MBAG_RST_BOUND    = 16'h0000;
  localparam logic [15:0] MBAG_RST_MODE_CTL = 16'h0fff;
  localparam logic [15:0] MBAG_RST_BREV_MOD = 16'h0000;

  // ------------------------------------------------------------------
  // Field layout
  // ------------------------------------------------------------------
  localparam int          MBAG_X_SEL_LSB  = 0;
  localparam int          MBAG_Y_SEL_LSB  = 4;
  localparam int          MBAG_B_SEL_LSB  = 8;
  localparam int          MBAG_X_EN_BIT   = 15;
  localparam int          MBAG_Y_EN_BIT   = 14;
  localparam int          MBAG_BITREV_ENABLE_BIT   = 15;
  localparam logic [3:0]  MBAG_SEL_OFF    = 4'hf;

  // Generator indices.
  localparam int MBAG_NGEN  = 3;
  localparam int MBAG_GEN_XR = 0;
  localparam int MBAG_GEN_XW = 1;
  localparam int MBAG_GEN_Y  = 2;

  // ------------------------------------------------------------------
  // Carrier types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    MBAG_AM_INDIRECT = 2'b00,
    MBAG_AM_POST_MOD = 2'b01,
    MBAG_AM_PRE_MOD  = 2'b11,
    MBAG_AM_OFFSET   = 2'b10
  } mbag_mode_t;

  typedef struct packed {
    logic        valid;
    logic [3:0]  wreg;
    mbag_mode_t  mode;
    logic [15:0] ptr;
    logic [15:0] modifier;
    logic        byte_size;
    logic        is_write;
  } mbag_req_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] ea;
    logic        wb_en;
    logic [15:0] wb_value;
  } mbag_rsp_t;

endpackage

`default_nettype wire

/* src/mbag_top.sv */
// Modulo (circular) and bit-reversed effective-address correction for the
// X read, X write and Y address generators, with its APB register file.
// Assumes requests come from core logic on pclk and need no synchroniser.

`default_nettype none

module mbag_top
  import mbag_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // Address generator requests and answers
  input  wire mbag_req_t   agu_req [MBAG_NGEN],
  output var  mbag_rsp_t   agu_rsp [MBAG_NGEN]
);

  // ------------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------------

  // Mirror a 16-bit word end for end.
  function automatic logic [15:0] mirror16(input logic [15:0] v);
    logic [15:0] r;
    r = '0;
    for (int i = 0; i < 16; i++)
    begin
      r[i] = v[15 - i];
    end
    return r;
  endfunction

  // Reversed-carry sum: mirror, add, mirror back, so carries run from
  // the top bit toward the bottom.
  function automatic logic [15:0] rc_add(input logic [15:0] a, input logic [15:0] b);
    logic [15:0] s;
    s = mirror16(a) + mirror16(b);
    return mirror16(s); // [RL21]
  endfunction

  // ------------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------------
  logic [15:0] x_circ_start;
  logic [15:0] x_circ_end;
  logic [15:0] y_circ_start;
  logic [15:0] y_circ_end;
  logic [15:0] addr_mode_control;
  logic [15:0] bitrev_modifier;
  logic [15:0] brev_last;

  // Decode of the APB request.
  wire         apb_setup  = psel & ~penable;
  wire         apb_wr_go  = psel & penable & pready & pwrite;
  wire         hit_xs     = (paddr == MBAG_OFF_X_START);
  wire         hit_xe     = (paddr == MBAG_OFF_X_END);
  wire         hit_ys     = (paddr == MBAG_OFF_Y_START);
  wire         hit_ye     = (paddr == MBAG_OFF_Y_END);
  wire         hit_mc     = (paddr == MBAG_OFF_MODE_CTL);
  wire         hit_bm     = (paddr == MBAG_OFF_BREV_MOD);
  wire         hit_bl     = (paddr == MBAG_OFF_BREV_LAST);
  wire         hit_rw     = hit_xs | hit_xe | hit_ys | hit_ye | hit_mc | hit_bm;
  wire         hit_any    = hit_rw | hit_bl;
  // Writes to the read-only status word are answered with an error.
  wire         bad_access = ~hit_any | (pwrite & hit_bl);

  // Byte-lane merge of write data into a 16-bit register.
  function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
                                             input logic [31:0] wd,
                                             input logic [3:0]  st);
    logic [15:0] r;
    r = old_v;
    if (st[0])
    begin
      r[7:0] = wd[7:0];
    end
    if (st[1])
    begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  // Read mux; upper half of the word always reads zero.
  logic [15:0] rd_mux;
  assign rd_mux = hit_xs ? x_circ_start      :
                  hit_xe ? x_circ_end        :
                  hit_ys ? y_circ_start      :
                  hit_ye ? y_circ_end        :
                  hit_mc ? addr_mode_control :
                  hit_bm ? bitrev_modifier   :
                  hit_bl ? brev_last         : 16'h0000;

  // The answer is prepared in the setup cycle so that pready, prdata and
  // pslverr all leave flip-flops; every transfer takes exactly one wait-free
  // access cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= apb_setup;
      pslverr <= apb_setup & bad_access;
      prdata  <= (apb_setup & ~pwrite) ? {16'h0000, rd_mux} : 32'h0000_0000;
    end
  end

  // Boundary and control registers; a refused write stores nothing.
  wire wr_ok = apb_wr_go & ~pslverr;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      x_circ_start      <= MBAG_RST_BOUND;    // [RL4]
      x_circ_end        <= MBAG_RST_BOUND;
      y_circ_start      <= MBAG_RST_BOUND;
      y_circ_end        <= MBAG_RST_BOUND;
      addr_mode_control <= MBAG_RST_MODE_CTL;
      bitrev_modifier   <= MBAG_RST_BREV_MOD;
    end
    else if (wr_ok)
    begin
      if (hit_xs)
      begin
        x_circ_start <= lane_merge(x_circ_start, pwdata, pstrb);
      end
      if (hit_xe)
      begin
        x_circ_end <= lane_merge(x_circ_end, pwdata, pstrb);
      end
      if (hit_ys)
      begin
        y_circ_start <= lane_merge(y_circ_start, pwdata, pstrb);
      end
      if (hit_ye)
      begin
        y_circ_end <= lane_merge(y_circ_end, pwdata, pstrb);
      end
      if (hit_mc)
      begin
        addr_mode_control <= lane_merge(addr_mode_control, pwdata, pstrb);
      end
      if (hit_bm)
      begin
        bitrev_modifier <= lane_merge(bitrev_modifier, pwdata, pstrb);
      end
    end
  end

  // ------------------------------------------------------------------
  // Control fields
  // ------------------------------------------------------------------
  wire [3:0]  x_circ_pointer_sel = addr_mode_control[MBAG_X_SEL_LSB +: 4];
  wire [3:0]  y_circ_pointer_sel = addr_mode_control[MBAG_Y_SEL_LSB +: 4];
  wire [3:0]  bitrev_pointer_sel = addr_mode_control[MBAG_B_SEL_LSB +: 4];
  wire        x_circ_enable      = addr_mode_control[MBAG_X_EN_BIT];
  wire        y_circ_enable      = addr_mode_control[MBAG_Y_EN_BIT];
  wire        bitrev_enable      = bitrev_modifier[MBAG_BITREV_ENABLE_BIT];
  wire [14:0] bitrev_pivot       = bitrev_modifier[14:0];

  // One select of 1111 turns a space off entirely.
  wire x_circ_on = (x_circ_pointer_sel != MBAG_SEL_OFF) & x_circ_enable; // [RL7] [RL8]
  wire y_circ_on = (y_circ_pointer_sel != MBAG_SEL_OFF) & y_circ_enable; // [RL7] [RL9]
  wire brev_on   = (bitrev_pointer_sel != MBAG_SEL_OFF) & bitrev_enable; // [RL14]

  // Pivot is a word count; shift it to a byte step.
  wire [15:0] brev_step = {bitrev_pivot, 1'b0}; // [RL16]

  // Buffer lengths follow from the boundaries; a full 64 Kbyte buffer gives
  // zero here, and adding or removing zero is exactly the right wrap.
  wire [15:0] x_len = x_circ_end - x_circ_start + 16'h0001; // [RL6]
  wire [15:0] y_len = y_circ_end - y_circ_start + 16'h0001; // [RL6]

  // ------------------------------------------------------------------
  // Per-generator datapath
  // ------------------------------------------------------------------
  logic [MBAG_NGEN-1:0] brev_used;
  logic [15:0]          brev_addr [MBAG_NGEN];

  for (genvar g = 0; g < MBAG_NGEN; g++)
  begin : gen_agu
    localparam bit IS_Y    = (g == MBAG_GEN_Y);
    localparam bit CAN_REV = (g == MBAG_GEN_XW);

    mbag_req_t   rq;
    logic [15:0] lo_b;
    logic [15:0] hi_b;
    logic [15:0] len;
    logic        circ_sel;
    logic [16:0] sum_ext;
    logic [15:0] sum;
    logic        going_down;
    logic        past_hi;
    logic        past_lo;
    logic [15:0] wrapped;
    logic [15:0] moved;
    logic        modify;
    logic        is_incr;
    logic        rev_hit;
    logic [15:0] rev_next;
    logic [15:0] fwd_ea;
    logic [15:0] fwd_ptr;
    logic [15:0] ea_raw;
    mbag_rsp_t   next_rsp;

    assign rq   = agu_req[g];
    assign lo_b = IS_Y ? y_circ_start : x_circ_start;
    assign hi_b = IS_Y ? y_circ_end   : x_circ_end;
    assign len  = IS_Y ? y_len        : x_len;

    // X read and X write share the X buffer; Y has its own. [RL1]
    assign circ_sel = IS_Y ? (y_circ_on & (rq.wreg == y_circ_pointer_sel))
                           : (x_circ_on & (rq.wreg == x_circ_pointer_sel));

    // Direction comes from the modifier sign, so a power-of-two buffer can
    // be walked either way; other buffers are simply used one way. [RL3]
    assign sum_ext    = {1'b0, rq.ptr} + {rq.modifier[15], rq.modifier};
    assign sum        = sum_ext[15:0];
    assign going_down = rq.modifier[15];

    // Checks are strict greater-than and less-than comparisons, so a step that jumps past the
    // limit still folds back into the buffer. A carry or borrow out of
    // 16 bits also counts as past the limit, otherwise a buffer that
    // starts at zero or ends at the top of memory would never wrap. [RL10]
    assign past_hi = ~going_down & (sum_ext[16] | (sum > hi_b));
    assign past_lo = going_down & (sum_ext[16] | (sum < lo_b));
    assign wrapped = past_hi ? (sum - len) :
                     past_lo ? (sum + len) : sum;
    assign moved   = circ_sel ? wrapped : sum;

    assign modify  = (rq.mode == MBAG_AM_POST_MOD) | (rq.mode == MBAG_AM_PRE_MOD);
    assign is_incr = modify & ~rq.modifier[15] & (rq.modifier != 16'h0000);

    // Reversal only on the X write generator, word writes, pre or post
    // increment; anything else falls back to normal addresses.
    assign rev_hit = CAN_REV & brev_on & rq.is_write & ~rq.byte_size & is_incr
                     & (rq.wreg == bitrev_pointer_sel); // [RL12] [RL17]

    // Pointer stays in normal order, only the step is reversed, the
    // instruction's own offset is dropped and the LSb is cleared.
    assign rev_next = {rc_add(rq.ptr, brev_step)} & 16'hfffe; // [RL13] [RL18]

    // Ordinary path: post-modify uses the old pointer, pre-modify and the
    // indexed form use the corrected sum, plain indirect uses the pointer.
    assign fwd_ea  = (rq.mode == MBAG_AM_POST_MOD) ? rq.ptr :
                     (rq.mode == MBAG_AM_INDIRECT) ? rq.ptr : moved;
    assign fwd_ptr = moved;

    // Reversal wins over circular correction on a shared pointer. [RL19]
    assign ea_raw = rev_hit ? ((rq.mode == MBAG_AM_PRE_MOD) ? rev_next : rq.ptr)
                            : fwd_ea;

    always_comb
    begin
      next_rsp.valid    = rq.valid;
      // Y circular work is word-only, hence the cleared LSb. [RL5]
      next_rsp.ea       = (IS_Y && circ_sel) ? (ea_raw & 16'hfffe) : ea_raw;
      // Only pre- and post-modify write the pointer back. [RL11]
      next_rsp.wb_en    = rq.valid & modify;
      next_rsp.wb_value = rev_hit ? rev_next :
                          ((IS_Y && circ_sel) ? (fwd_ptr & 16'hfffe) : fwd_ptr);
    end

    assign brev_used[g] = rq.valid & rev_hit;
    assign brev_addr[g] = rev_next;

    // Answers leave flip-flops one cycle after the request.
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        agu_rsp[g] <= '0;
      end
      else
      begin
        agu_rsp[g] <= next_rsp;
      end
    end
  end

  // ------------------------------------------------------------------
  // Status: last bit-reversed pointer produced
  // ------------------------------------------------------------------

  // Lets software follow an FFT reorder pass without reading the pointer.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      brev_last <= MBAG_RST_BOUND;
    end
    else if (brev_used[MBAG_GEN_XW])
    begin
      brev_last <= brev_addr[MBAG_GEN_XW];
    end
  end

endmodule

`default_nettype wire

/* tb/mbag_props.sv */
// Checker for mbag_top ports: APB answer timing and address generator answers.
// Assumes full-width APB writes, so the mode and modifier shadows stay exact.
`default_nettype none
module mbag_props
  import mbag_pkg::*;
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Address generators
  input wire mbag_req_t   agu_req [MBAG_NGEN],
  input wire mbag_rsp_t   agu_rsp [MBAG_NGEN]
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------------
  // Register shadows
  // ------------------------------------------------------------------
  logic [15:0] mc;
  logic [15:0] br;
  // Shadows follow completed writes, so the checks below know each mode.
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      mc <= 16'h0fff;
      br <= 16'h0000;
    end
    else if (psel && penable && pready && pwrite)
    begin
      if (paddr == MBAG_OFF_MODE_CTL) mc <= pwdata[15:0];
      if (paddr == MBAG_OFF_BREV_MOD) br <= pwdata[15:0];
    end
  // Decoded conditions; a reversed step needs a positive non-zero modifier.
  wire logic x_off  = !mc[15] || mc[3:0] == 4'hf;
  wire logic y_off  = !mc[14] || mc[7:4] == 4'hf;
  wire logic g1_stp = agu_req[1].valid && agu_req[1].mode[0] && agu_req[1].is_write;
  wire logic b_hit  = g1_stp && br[15] && mc[11:8] != 4'hf && agu_req[1].wreg == mc[11:8]
                      && !agu_req[1].byte_size && !agu_req[1].modifier[15]
                      && agu_req[1].modifier != 16'h0;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  property p_apb_answer;
    s_setup |=> s_answer;
  endproperty
  a_apb_answer: assert property (p_apb_answer)
    else $error("APB answer not a single cycle after setup.");
  property p_apb_err;
    psel && penable && (paddr > 8'h18 || (pwrite && paddr == 8'h18)) |-> pslverr;
  endproperty
  a_apb_err: assert property (p_apb_err)
    else $error("Bad APB access not flagged.");
  property p_rsp_valid;
    agu_req[1].valid |=> agu_rsp[1].valid;
  endproperty
  a_rsp_valid: assert property (p_rsp_valid)
    else $error("Write generator answer missing.");
  property p_wb;
    agu_req[0].valid |=> agu_rsp[0].wb_en == $past(agu_req[0].mode[0]);
  endproperty
  a_wb: assert property (p_wb)
    else $error("Pointer write-back wrong for the mode.");
  property p_post_ea;
    agu_req[0].valid && agu_req[0].mode == MBAG_AM_POST_MOD
      |=> agu_rsp[0].ea == $past(agu_req[0].ptr);
  endproperty
  a_post_ea: assert property (p_post_ea)
    else $error("Post-modify address is not the old pointer.");
  property p_x_plain;
    agu_req[0].valid && agu_req[0].mode[0] && x_off
      |=> agu_rsp[0].wb_value == $past(agu_req[0].ptr) + $past(agu_req[0].modifier);
  endproperty
  a_x_plain: assert property (p_x_plain)
    else $error("X read pointer corrected while circular mode is off.");
  property p_y_plain;
    agu_req[2].valid && agu_req[2].mode[0] && y_off
      |=> agu_rsp[2].wb_value == $past(agu_req[2].ptr) + $past(agu_req[2].modifier);
  endproperty
  a_y_plain: assert property (p_y_plain)
    else $error("Y pointer corrected while circular mode is off.");
  property p_brev_lsb;
    b_hit |=> agu_rsp[1].wb_en && !agu_rsp[1].wb_value[0];
  endproperty
  a_brev_lsb: assert property (p_brev_lsb)
    else $error("Reversed pointer has its low bit set.");
  property p_byte_plain;
    g1_stp && agu_req[1].byte_size && x_off
      |=> agu_rsp[1].wb_value == $past(agu_req[1].ptr) + $past(agu_req[1].modifier);
  endproperty
  a_byte_plain: assert property (p_byte_plain)
    else $error("Byte write pointer not stepped normally.");
endmodule
bind mbag_top mbag_props i_props (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .agu_req(agu_req), .agu_rsp(agu_rsp));
`default_nettype wire

/* tb/mbag_core_model.sv */
// Core-side model: issues one address generator request and takes its answer.
// Assumes the answer stands in the cycle after the request edge.
`default_nettype none
module mbag_core_model
  import mbag_pkg::*;
(
  // Clock
  input  wire logic      pclk,
  // Requests out, answers in
  output var  mbag_req_t agu_req [MBAG_NGEN],
  input  wire mbag_rsp_t agu_rsp [MBAG_NGEN]
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle at time zero.
  initial
  begin
    for (int g = 0; g < MBAG_NGEN; g++)
      agu_req[g] = '0;
  end
  // Callers keep stack registers out of circular use and leave a gap after
  // a modifier write; idle lines show the inverted payload, not stale data.
  task automatic issue(input int g, input mbag_req_t r, output mbag_rsp_t a);
    mbag_req_t q;
    q = ~r;
    q.valid = 1'b0;
    @(posedge pclk);
    agu_req[g] <= r;
    @(posedge pclk);
    agu_req[g] <= q;
    @(negedge pclk);
    a = agu_rsp[g];
  endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for mbag_top: register access and address corrections.
// Assumes the core-side model and the bound checker are compiled alongside.
`default_nettype none
module tb
  import mbag_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [7:0]  paddr = '0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = '0;
  logic [3:0]  pstrb = 4'hf;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] q;
  logic        e;
  mbag_req_t   agu_req [MBAG_NGEN];
  mbag_rsp_t   agu_rsp [MBAG_NGEN];
  mbag_rsp_t   a;
  int          bad_count = 0;
  int          samples_checked = 0;
  int          idx [9] = '{0, 8, 4, 12, 2, 10, 6, 14, 1};
  always #2 pclk = ~pclk;
  mbag_top i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .agu_req(agu_req), .agu_rsp(agu_rsp));
  mbag_core_model i_core (.pclk(pclk), .agu_req(agu_req), .agu_rsp(agu_rsp));
  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; the slave's wait is bounded so a hang ends the run.
  task automatic apb(input logic [7:0] ad, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    paddr <= ad;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      bad_count++;
      results();
    end
  endtask
  // Pointer register 1 throughout; the write-back value counts only when enabled.
  task automatic agu(input int g, input mbag_mode_t m, input logic [15:0] p, input logic [15:0] md,
                     input logic bs, input logic [15:0] ea, input logic wb, input logic [15:0] wv);
    i_core.issue(g, '{1'b1, 4'h1, m, p, md, bs, g == 1}, a);
    check({a.valid, a.ea, a.wb_en, wb ? a.wb_value : 16'h0}, {1'b1, ea, wb, wb ? wv : 16'h0});
  endtask
  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial
  begin
    static logic [15:0] rst_exp [7] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0fff, 16'h0, 16'h0};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 7; i++)
    begin
      apb(8'(4 * i), 1'b0, '0);
      check({1'b0, e, q}, {18'h0, rst_exp[i]});
    end
    apb(MBAG_OFF_X_START, 1'b1, 32'h1100);
    apb(MBAG_OFF_X_END, 1'b1, 32'h1163);
    apb(MBAG_OFF_Y_START, 1'b1, 32'h2000);
    apb(MBAG_OFF_Y_END, 1'b1, 32'h200f);
    apb(MBAG_OFF_X_END, 1'b0, '0);
    check({1'b0, e, q}, 34'h1163);
    apb(8'h1c, 1'b0, '0);
    check({1'b0, e, q}, {2'b01, 32'h0});
    apb(MBAG_OFF_BREV_LAST, 1'b1, 32'h5);
    check({2'b0, e, 31'h0}, {2'b0, 1'b1, 31'h0});
    $display("Test registers done.");
    apb(MBAG_OFF_MODE_CTL, 1'b1, 32'hcf11);
    agu(0, MBAG_AM_POST_MOD, 16'h1162, 16'h0002, 0, 16'h1162, 1, 16'h1100);
    agu(1, MBAG_AM_POST_MOD, 16'h1162, 16'h0004, 0, 16'h1162, 1, 16'h1102);
    agu(0, MBAG_AM_PRE_MOD, 16'h1100, 16'hfffe, 0, 16'h1162, 1, 16'h1162);
    agu(0, MBAG_AM_OFFSET, 16'h1162, 16'h0002, 0, 16'h1100, 0, 16'h0);
    agu(0, MBAG_AM_INDIRECT, 16'h1162, 16'h0002, 0, 16'h1162, 0, 16'h0);
    agu(2, MBAG_AM_POST_MOD, 16'h200e, 16'h0002, 0, 16'h200e, 1, 16'h2000);
    agu(2, MBAG_AM_PRE_MOD, 16'h200f, 16'h0002, 0, 16'h2000, 1, 16'h2000);
    apb(MBAG_OFF_MODE_CTL, 1'b1, 32'h0f11);
    agu(0, MBAG_AM_POST_MOD, 16'h1162, 16'h0002, 0, 16'h1162, 1, 16'h1164);
    agu(2, MBAG_AM_POST_MOD, 16'h200e, 16'h0002, 0, 16'h200e, 1, 16'h2010);
    apb(MBAG_OFF_MODE_CTL, 1'b1, 32'hcfff);
    agu(1, MBAG_AM_POST_MOD, 16'h1162, 16'h0002, 0, 16'h1162, 1, 16'h1164);
    agu(2, MBAG_AM_POST_MOD, 16'h200e, 16'h0002, 0, 16'h200e, 1, 16'h2010);
    apb(MBAG_OFF_MODE_CTL, 1'b1, 32'hcf22);
    agu(0, MBAG_AM_POST_MOD, 16'h1162, 16'h0002, 0, 16'h1162, 1, 16'h1164);
    $display("Test circular buffers done.");
    // Reversed buffer starts at zero, so its low bits are clear.
    apb(MBAG_OFF_BREV_MOD, 1'b1, 32'h8008);
    apb(MBAG_OFF_MODE_CTL, 1'b1, 32'h01ff);
    for (int i = 0; i < 8; i++)
      agu(1, MBAG_AM_POST_MOD, 16'(2 * idx[i]), 16'h0002, 0, 16'(2 * idx[i]), 1,
          16'(2 * idx[i + 1]));
    agu(1, MBAG_AM_PRE_MOD, 16'h000c, 16'h0006, 0, 16'h001c, 1, 16'h001c);
    agu(1, MBAG_AM_POST_MOD, 16'h0010, 16'h0001, 1, 16'h0010, 1, 16'h0011);
    agu(0, MBAG_AM_POST_MOD, 16'h0010, 16'h0002, 0, 16'h0010, 1, 16'h0012);
    agu(1, MBAG_AM_OFFSET, 16'h0010, 16'h0002, 0, 16'h0012, 0, 16'h0);
    apb(MBAG_OFF_BREV_MOD, 1'b1, 32'h0008);
    agu(1, MBAG_AM_POST_MOD, 16'h0010, 16'h0002, 0, 16'h0010, 1, 16'h0012);
    $display("Test bit reversal done.");
    apb(MBAG_OFF_BREV_MOD, 1'b1, 32'h8008);
    apb(MBAG_OFF_X_START, 1'b1, 32'h0000);
    apb(MBAG_OFF_X_END, 1'b1, 32'h001f);
    apb(MBAG_OFF_MODE_CTL, 1'b1, 32'h81f1);
    agu(1, MBAG_AM_POST_MOD, 16'h001c, 16'h0002, 0, 16'h001c, 1, 16'h0002);
    agu(0, MBAG_AM_POST_MOD, 16'h001e, 16'h0002, 0, 16'h001e, 1, 16'h0000);
    agu(0, MBAG_AM_PRE_MOD, 16'h0000, 16'hfffe, 0, 16'h001e, 1, 16'h001e);
    apb(MBAG_OFF_BREV_LAST, 1'b0, '0);
    check({1'b0, e, q}, 34'h0002);
    $display("Test precedence done.");
    results();
  end
endmodule
`default_nettype wire
